// file: hw/dlc_regs.sv
// data link control, read/write offset and status registers of the slave controller
// assumes both access ports, the frame engine and the port logic share sys_clk_i
`timescale 1ns/1ps
`default_nettype none
module dlc_regs
  import dlc_pkg::*;
#(
  parameter int RLD_LONG_CYC = RLD_LONG_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // network side register access
  input wire logic [15:0] net_addr_i,
  input wire logic net_rd_i,
  input wire logic net_wr_i,
  input wire logic [3:0] net_be_i,
  input wire logic [31:0] net_wdata_i,
  output logic [31:0] net_rdata_o,
  output logic net_ev_clear_o,
  // process data interface register access
  input wire logic [15:0] pdi_addr_i,
  input wire logic pdi_rd_i,
  input wire logic pdi_wr_i,
  output logic [31:0] pdi_rdata_o,
  // configuration memory load
  input wire logic cfg_load_i,
  input wire logic cfg_load_ok_i,
  input wire logic [2:0] cfg_fifo_size_i,
  input wire logic cfg_enh_link_i,
  // process data interface state
  input wire logic pdi_ram_access_i,
  input wire logic wd_reloaded_i,
  // port state
  input wire logic [3:0] port_link_i,
  input wire logic [3:0] port_comm_i,
  input wire logic [3:0] port_busy_i,
  input wire logic [3:0] port_frame_ok_i,
  // command addressing
  input wire logic [15:0] cmd_addr_i,
  input wire logic [15:0] station_addr_i,
  input wire logic [15:0] station_alias_i,
  input wire logic rld_start_i,
  // settings driven to the link logic
  output logic [2:0] fifo_size_o,
  output logic fwd_delay_trim_o,
  output logic low_jitter_o,
  output logic rld_active_o,
  output logic alias_match_o,
  output logic [15:0] rd_addr_o,
  output logic [15:0] wr_addr_o,
  output logic [7:0] loop_applied_o
);
  logic [2:0] fifo_size_q;
  logic low_jitter_q;
  logic rld_short_q;
  logic alias_en_q;
  logic [2:0] rsv_q;
  logic [7:0] loop_cfg_q;
  logic [15:0] rw_offset_q;
  logic first_load_done_q;
  logic cfg_ok_q;
  logic enh_link_q;
  logic [31:0] rld_cnt_q;
  logic [31:0] net_rdata_q;
  logic [31:0] pdi_rdata_q;
  logic net_ev_clear_q;
  logic fwd_trim_q;
  logic rld_active_q;
  logic alias_match_q;
  logic [15:0] rd_addr_q;
  logic [15:0] wr_addr_q;
  logic [7:0] loop_applied;
  logic [3:0] loop_closed;
  logic [15:0] status;
  logic net_wr_ctl;
  logic net_wr_off;
  logic first_load;

  // only the network port can write; the pdi write strobe is deliberately unused
  assign net_wr_ctl = net_wr_i && net_addr_i == OFF_CONTROL;
  assign net_wr_off = net_wr_i && net_addr_i == OFF_RW_OFFSET;
  assign first_load = cfg_load_i && !first_load_done_q;

  function automatic logic [31:0] read_word(input logic [15:0] addr);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (addr == OFF_CONTROL) begin
      w[CTL_LOOP_LSB +: 8] = loop_cfg_q;
      w[CTL_FIFO_MSB:CTL_FIFO_LSB] = fifo_size_q;
      w[CTL_LOW_JITTER] = low_jitter_q;
      w[CTL_RSV_LO_MSB:CTL_RSV_LO_LSB] = rsv_q[1:0];
      w[CTL_RLD_SHORT] = rld_short_q;
      w[CTL_RSV_HI] = rsv_q[2];
      w[CTL_ALIAS_EN] = alias_en_q;
    end else if (addr == OFF_RW_OFFSET) begin
      w[15:0] = rw_offset_q;
    end else if (addr == OFF_STATUS) begin
      w[15:0] = status;
    end
    return w;
  endfunction

  always_comb begin
    status = 16'h0000;
    status[ST_PDI_OPER] = cfg_ok_q && pdi_ram_access_i;
    status[ST_WD_RELOADED] = wd_reloaded_i;
    status[ST_ENH_LINK] = enh_link_q;
    status[ST_LINK_LSB +: NUM_PORTS] = port_link_i;
    for (int n = 0; n < NUM_PORTS; n++) begin
      status[ST_PORT_LSB + 2 * n] = loop_closed[n];
      status[ST_PORT_LSB + 2 * n + 1] = port_comm_i[n];
    end
  end

  // first configuration load after reset sets the fifo size unless a network control write to byte 2 lands in the same cycle; later loads do not
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      first_load_done_q <= 1'b0;
      enh_link_q <= 1'b0;
      cfg_ok_q <= 1'b0;
    end else if (cfg_load_i) begin
      first_load_done_q <= 1'b1;
      cfg_ok_q <= cfg_load_ok_i;
      if (first_load) begin
        enh_link_q <= cfg_enh_link_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fifo_size_q <= FIFO_SIZE_RST;
    end else if (net_wr_ctl && net_be_i[2]) begin
      fifo_size_q <= net_wdata_i[CTL_FIFO_MSB:CTL_FIFO_LSB];
    end else if (first_load) begin
      fifo_size_q <= cfg_fifo_size_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_jitter_q <= LOW_JITTER_RST;
      rld_short_q <= RLD_SHORT_RST;
      alias_en_q <= ALIAS_EN_RST;
      rsv_q <= 3'h0;
      loop_cfg_q <= 8'h00;
    end else if (net_wr_ctl) begin
      if (net_be_i[1]) begin
        loop_cfg_q <= net_wdata_i[CTL_LOOP_LSB +: 8];
      end
      if (net_be_i[2]) begin
        low_jitter_q <= net_wdata_i[CTL_LOW_JITTER];
        rsv_q[1:0] <= net_wdata_i[CTL_RSV_LO_MSB:CTL_RSV_LO_LSB];
        rld_short_q <= net_wdata_i[CTL_RLD_SHORT];
        rsv_q[2] <= net_wdata_i[CTL_RSV_HI];
      end
      if (net_be_i[3]) begin
        alias_en_q <= net_wdata_i[CTL_ALIAS_EN];
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rw_offset_q <= RW_OFFSET_RST;
    end else if (net_wr_off) begin
      if (net_be_i[0]) begin
        rw_offset_q[7:0] <= net_wdata_i[7:0];
      end
      if (net_be_i[1]) begin
        rw_offset_q[15:8] <= net_wdata_i[15:8];
      end
    end
  end

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    dlc_loop_port u_loop (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .cfg_wr_i(net_wr_ctl && net_be_i[1]),
      .cfg_i(net_wdata_i[CTL_LOOP_LSB + 2 * p +: 2]),
      .busy_i(port_busy_i[p]),
      .link_i(port_link_i[p]),
      .frame_ok_i(port_frame_ok_i[p]),
      .applied_o(loop_applied[2 * p +: 2]),
      .closed_o(loop_closed[p])
    );
  end

  // register reads answer one cycle after the strobe; unmapped words read zero
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      net_rdata_q <= 32'h0000_0000;
      pdi_rdata_q <= 32'h0000_0000;
      net_ev_clear_q <= 1'b0;
    end else begin
      if (net_rd_i) begin
        net_rdata_q <= read_word(net_addr_i);
      end
      if (pdi_rd_i) begin
        pdi_rdata_q <= read_word(pdi_addr_i);
      end
      net_ev_clear_q <= net_rd_i && net_addr_i == OFF_STATUS;
    end
  end

  // one counter serves both link down times; a restart reloads it
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rld_cnt_q <= 32'h0000_0000;
      rld_active_q <= 1'b0;
    end else if (rld_start_i) begin
      rld_cnt_q <= rld_short_q ? 32'(RLD_SHORT_CYCLES) : 32'(RLD_LONG_CYC);
      rld_active_q <= 1'b1;
    end else if (rld_cnt_q > 32'h0000_0001) begin
      rld_cnt_q <= rld_cnt_q - 32'h0000_0001;
    end else begin
      rld_cnt_q <= 32'h0000_0000;
      rld_active_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fwd_trim_q <= 1'b0;
      alias_match_q <= 1'b0;
      rd_addr_q <= 16'h0000;
      wr_addr_q <= 16'h0000;
    end else begin
      fwd_trim_q <= fifo_size_q <= FIFO_REDUCE_MAX;
      alias_match_q <= cmd_addr_i == station_addr_i ||
                       (alias_en_q && cmd_addr_i == station_alias_i);
      rd_addr_q <= cmd_addr_i;
      wr_addr_q <= 16'(cmd_addr_i + rw_offset_q);
    end
  end

  assign net_rdata_o = net_rdata_q;
  assign pdi_rdata_o = pdi_rdata_q;
  assign net_ev_clear_o = net_ev_clear_q;
  assign fifo_size_o = fifo_size_q;
  assign fwd_delay_trim_o = fwd_trim_q;
  assign low_jitter_o = low_jitter_q;
  assign rld_active_o = rld_active_q;
  assign alias_match_o = alias_match_q;
  assign rd_addr_o = rd_addr_q;
  assign wr_addr_o = wr_addr_q;
  assign loop_applied_o = loop_applied;

  sequence s_status_read;
    net_rd_i && net_addr_i == OFF_STATUS;
  endsequence

  sequence s_later_load;
    cfg_load_i && first_load_done_q && !net_wr_ctl;
  endsequence

  a_fifo_trim: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ##1 fwd_delay_trim_o == ($past(fifo_size_q) <= FIFO_REDUCE_MAX))
    else $error("fifo delay trim does not follow fifo size");
  a_later_load_kept: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_later_load |=> $stable(fifo_size_q) && $stable(enh_link_q))
    else $error("later config load changed fifo size or link setting");
  a_jitter_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    net_wr_ctl && net_be_i[2] |=> low_jitter_o == $past(net_wdata_i[CTL_LOW_JITTER]))
    else $error("low jitter bit not written");
  a_rld_short: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rld_start_i && rld_short_q && !net_wr_ctl ##1 !rld_start_i [*8]
      |-> rld_active_o)
    else $error("short link down signal ended early");
  a_alias_ignored: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !alias_en_q && cmd_addr_i != station_addr_i |=> !alias_match_o)
    else $error("alias matched while disabled");
  a_loop_wait: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    port_busy_i[0] && $stable(port_busy_i[0]) |=> $stable(loop_applied_o[1:0]) or
      !$past(port_busy_i[0]))
    else $error("loop setting applied during a frame");
  // the edge that releases reset still sees reset in the design, so skip that one
  a_rw_offset: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !$past(rst_i) |-> wr_addr_o == 16'($past(cmd_addr_i) + $past(rw_offset_q)) &&
      rd_addr_o == $past(cmd_addr_i))
    else $error("read-write address pair wrong");
  a_status_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_status_read |=> net_ev_clear_o && net_rdata_o[15:0] == $past(status))
    else $error("status read did not clear event or return status");
  a_pdi_read_only: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    pdi_wr_i && !net_wr_i |=> $stable(rw_offset_q) && $stable(alias_en_q))
    else $error("pdi write changed a register");
  a_status_link: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    pdi_rd_i && pdi_addr_i == OFF_STATUS |=>
      pdi_rdata_o[ST_LINK_LSB +: NUM_PORTS] == $past(port_link_i) &&
      pdi_rdata_o[ST_PDI_OPER] == ($past(cfg_ok_q) && $past(pdi_ram_access_i)))
    else $error("status link or operational bit wrong");
endmodule
`default_nettype wire

// file: hw/dlc_pkg.sv
// package for the data link control and status register bank
// assumes a single 40 MHz clock shared by both register access ports
package dlc_pkg;
  localparam int CLK_MHZ = 40;
  localparam int ADDR_W = 16;
  // byte addresses of the three word registers
  localparam logic [15:0] OFF_CONTROL = 16'h0100;
  localparam logic [15:0] OFF_RW_OFFSET = 16'h0108;
  localparam logic [15:0] OFF_STATUS = 16'h0110;
  // control field positions
  localparam int CTL_LOOP_LSB = 8;
  localparam int CTL_FIFO_LSB = 16;
  localparam int CTL_FIFO_MSB = 18;
  localparam int CTL_LOW_JITTER = 19;
  localparam int CTL_RSV_LO_LSB = 20;
  localparam int CTL_RSV_LO_MSB = 21;
  localparam int CTL_RLD_SHORT = 22;
  localparam int CTL_RSV_HI = 23;
  localparam int CTL_ALIAS_EN = 24;
  // status field positions
  localparam int ST_PDI_OPER = 0;
  localparam int ST_WD_RELOADED = 1;
  localparam int ST_ENH_LINK = 2;
  localparam int ST_LINK_LSB = 4;
  localparam int ST_PORT_LSB = 8;
  localparam int NUM_PORTS = 4;
  // reset values, and the largest fifo size that still trims the forward delay
  localparam logic [2:0] FIFO_SIZE_RST = 3'h7;
  localparam logic [2:0] FIFO_REDUCE_MAX = 3'h3;
  localparam logic LOW_JITTER_RST = 1'b0;
  localparam logic RLD_SHORT_RST = 1'b0;
  localparam logic ALIAS_EN_RST = 1'b0;
  localparam logic [15:0] RW_OFFSET_RST = 16'h0000;
  // remote link down signalling time
  localparam int RLD_LONG_MS = 660;
  localparam int RLD_SHORT_US = 80;
  localparam int RLD_LONG_CYCLES = RLD_LONG_MS * 1000 * CLK_MHZ;
  localparam int RLD_SHORT_CYCLES = RLD_SHORT_US * CLK_MHZ;

  typedef enum logic [1:0] {
    LOOP_AUTO = 2'b00,
    LOOP_AUTO_CLOSE = 2'b01,
    LOOP_OPEN = 2'b10,
    LOOP_CLOSED = 2'b11
  } dlc_loop_type;
endpackage

// file: hw/dlc_loop_port.sv
// one port's loop setting: holds a newly written setting until the port is idle
// assumes busy_i is high for the whole frame being received or sent on the port
`timescale 1ns/1ps
`default_nettype none
module dlc_loop_port
  import dlc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic cfg_wr_i,
  input wire logic [1:0] cfg_i,
  input wire logic busy_i,
  input wire logic link_i,
  input wire logic frame_ok_i,
  output logic [1:0] applied_o,
  output logic closed_o
);
  logic pend_q;
  logic [1:0] pend_cfg_q;
  logic [1:0] applied_q;
  logic closed_q;
  logic apply_now;

  assign apply_now = pend_q && !busy_i;
  assign applied_o = applied_q;
  assign closed_o = closed_q;

  // a write in the apply cycle stays pending so it is not lost
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
      pend_cfg_q <= LOOP_AUTO;
    end else if (cfg_wr_i) begin
      pend_q <= 1'b1;
      pend_cfg_q <= cfg_i;
    end else if (apply_now) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      applied_q <= LOOP_AUTO;
    end else if (apply_now) begin
      applied_q <= pend_cfg_q;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      closed_q <= 1'b1;
    end else begin
      unique case (dlc_loop_type'(applied_q))
        LOOP_AUTO: closed_q <= !link_i;
        LOOP_AUTO_CLOSE: begin
          if (!link_i) begin
            closed_q <= 1'b1;
          end else if (frame_ok_i || (apply_now && pend_cfg_q == LOOP_AUTO_CLOSE)) begin
            closed_q <= 1'b0;
          end
        end
        LOOP_OPEN: closed_q <= 1'b0;
        LOOP_CLOSED: closed_q <= 1'b1;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: tb/dlc_host_model.sv
// partner model: network master and process data host issuing register accesses
// assumes the bank takes a strobe at a rising edge and answers after the next edge
`timescale 1ns/1ps
`default_nettype none
module dlc_host_model (
  input wire logic sys_clk_i,
  output logic [15:0] net_addr_o,
  output logic net_rd_o,
  output logic net_wr_o,
  output logic [3:0] net_be_o,
  output logic [31:0] net_wdata_o,
  input wire logic [31:0] net_rdata_i,
  output logic [15:0] pdi_addr_o,
  output logic pdi_rd_o,
  output logic pdi_wr_o,
  input wire logic [31:0] pdi_rdata_i
);
  initial begin
    net_addr_o = 16'h0000;
    net_rd_o = 1'b0;
    net_wr_o = 1'b0;
    net_be_o = 4'h0;
    net_wdata_o = 32'h00000000;
    pdi_addr_o = 16'h0000;
    pdi_rd_o = 1'b0;
    pdi_wr_o = 1'b0;
  end
  // released lines show the inverse so a stale address never looks valid
  task automatic net_wr(input logic [15:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge sys_clk_i);
    net_addr_o <= a;
    net_be_o <= be;
    net_wdata_o <= d;
    net_wr_o <= 1'b1;
    @(posedge sys_clk_i);
    net_wr_o <= 1'b0;
    net_addr_o <= ~a;
    net_wdata_o <= ~d;
    #1;
  endtask
  task automatic net_rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    net_addr_o <= a;
    net_rd_o <= 1'b1;
    @(posedge sys_clk_i);
    net_rd_o <= 1'b0;
    net_addr_o <= ~a;
    #1;
    d = net_rdata_i;
  endtask
  task automatic pdi_acc(input logic [15:0] a, input logic wr, output logic [31:0] d);
    @(posedge sys_clk_i);
    pdi_addr_o <= a;
    pdi_rd_o <= ~wr;
    pdi_wr_o <= wr;
    @(posedge sys_clk_i);
    pdi_rd_o <= 1'b0;
    pdi_wr_o <= 1'b0;
    pdi_addr_o <= ~a;
    #1;
    d = pdi_rdata_i;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_data_link_control_status.sv
// self-checking bench for the data link control and status bank
// assumes the host model issues register accesses; port state is driven here
`timescale 1ns/1ps
`default_nettype none
module tb_data_link_control_status;
  import dlc_pkg::*;
  localparam int LONG = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ld = 1'b0, ok = 1'b0, enh = 1'b0, ram = 1'b0, wd = 1'b0, rld = 1'b0;
  logic [2:0] csz = 3'h0;
  logic [3:0] lnk = 4'h0, com = 4'h0, bsy = 4'h0, fok = 4'h0;
  logic [15:0] cmd = 16'h0000, sta = 16'h1000, als = 16'h2000;
  logic [15:0] na, pa, ra, wa;
  logic nr, nw, pr, pw, evc, trim, lj, ract, am;
  logic [3:0] nbe;
  logic [31:0] nwd, nrd, prd, rd;
  logic [2:0] fsz;
  logic [7:0] lp;
  int error_cnt = 0;
  int n_checks = 0;
  int n;
  always #12.5 clk = ~clk;
  dlc_regs #(.RLD_LONG_CYC(LONG)) dut (.sys_clk_i(clk), .rst_i(rst), .net_addr_i(na),
    .net_rd_i(nr), .net_wr_i(nw), .net_be_i(nbe), .net_wdata_i(nwd), .net_rdata_o(nrd),
    .net_ev_clear_o(evc), .pdi_addr_i(pa), .pdi_rd_i(pr), .pdi_wr_i(pw), .pdi_rdata_o(prd),
    .cfg_load_i(ld), .cfg_load_ok_i(ok), .cfg_fifo_size_i(csz), .cfg_enh_link_i(enh),
    .pdi_ram_access_i(ram), .wd_reloaded_i(wd), .port_link_i(lnk), .port_comm_i(com),
    .port_busy_i(bsy), .port_frame_ok_i(fok), .cmd_addr_i(cmd), .station_addr_i(sta),
    .station_alias_i(als), .rld_start_i(rld), .fifo_size_o(fsz), .fwd_delay_trim_o(trim),
    .low_jitter_o(lj), .rld_active_o(ract), .alias_match_o(am), .rd_addr_o(ra),
    .wr_addr_o(wa), .loop_applied_o(lp));
  dlc_host_model h (.sys_clk_i(clk), .net_addr_o(na), .net_rd_o(nr), .net_wr_o(nw),
    .net_be_o(nbe), .net_wdata_o(nwd), .net_rdata_i(nrd), .pdi_addr_o(pa), .pdi_rd_o(pr),
    .pdi_wr_o(pw), .pdi_rdata_i(prd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cmd_go(input logic [15:0] a);
    @(posedge clk);
    cmd <= a;
    @(posedge clk);
    #1;
  endtask
  task automatic load(input logic [2:0] s, input logic e);
    @(posedge clk);
    csz <= s;
    enh <= e;
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    // the trim output follows the size one edge later
    @(posedge clk);
    #1;
  endtask
  task automatic rld_len(input int exp);
    @(posedge clk);
    rld <= 1'b1;
    @(posedge clk);
    rld <= 1'b0;
    #1;
    n = 0;
    while (ract === 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n, exp, "link down length");
  endtask
  task automatic s_reset;
    h.net_rd(OFF_CONTROL, rd);
    chk(rd, 32'h00070000, "control reset");
    chk({lj, ract, fsz}, 5'h07, "reset outputs");
    h.net_rd(OFF_STATUS, rd);
    chk(evc, 1'b1, "event clear");
    chk(rd, 32'h00005500, "status reset");
  endtask
  task automatic s_cfg;
    @(posedge clk);
    ram <= 1'b1;
    wd <= 1'b1;
    ok <= 1'b1;
    load(3'h2, 1'b1);
    chk({fsz, trim}, 4'h5, "first load");
    load(3'h5, 1'b0);
    chk(fsz, 3'h2, "second load");
    h.net_rd(OFF_STATUS, rd);
    chk(rd, 32'h00005507, "status loaded");
    h.pdi_acc(OFF_STATUS, 1'b0, rd);
    chk(rd, 32'h00005507, "pdi status");
    @(posedge clk);
    wd <= 1'b0;
    h.net_rd(OFF_STATUS, rd);
    chk(rd, 32'h00005505, "watchdog expired");
  endtask
  task automatic s_size;
    // the bench clocks are ideal, so every size may be chosen
    for (int i = 0; i < 8; i++) begin
      h.net_wr(OFF_CONTROL, 4'b0100, {13'h0000, 3'(i), 16'h0000});
      @(posedge clk);
      #1;
      chk({fsz, trim}, {3'(i), i <= 3}, "fifo size");
    end
  endtask
  task automatic s_ctl;
    h.net_wr(OFF_CONTROL, 4'b1101, 32'hFF4E00FF);
    chk({fsz, trim, lj}, 5'h19, "control fields");
    h.net_rd(OFF_CONTROL, rd);
    chk(rd, 32'h014E0000, "control readback");
    h.pdi_acc(OFF_CONTROL, 1'b1, rd);
    h.pdi_acc(OFF_CONTROL, 1'b0, rd);
    chk(rd, 32'h014E0000, "pdi write ignored");
  endtask
  task automatic s_rld;
    rld_len(RLD_SHORT_CYCLES);
    h.net_wr(OFF_CONTROL, 4'b0100, 32'h00070000);
    chk(lj, 1'b0, "normal jitter");
    rld_len(LONG);
  endtask
  task automatic s_alias;
    cmd_go(16'h2000);
    chk(am, 1'b1, "alias used");
    h.net_wr(OFF_CONTROL, 4'b1000, 32'h00000000);
    cmd_go(16'h1000);
    chk(am, 1'b1, "station match");
    cmd_go(16'h2000);
    chk(am, 1'b0, "alias ignored");
  endtask
  task automatic s_offset;
    h.net_wr(OFF_RW_OFFSET, 4'b0011, 32'h00000010);
    cmd_go(16'hFFF8);
    chk({ra, wa}, 32'hFFF80008, "rw addresses");
    h.pdi_acc(OFF_RW_OFFSET, 1'b0, rd);
    chk(rd, 32'h00000010, "pdi offset");
    h.net_rd(16'h0104, rd);
    chk(rd, 32'h00000000, "unmapped read");
  endtask
  task automatic s_loop;
    @(posedge clk);
    lnk <= 4'h2;
    com <= 4'h2;
    bsy <= 4'h1;
    h.net_rd(OFF_STATUS, rd);
    chk(rd, 32'h00005925, "port 1 up");
    h.net_wr(OFF_CONTROL, 4'b0010, 32'h00000200);
    repeat (4) @(posedge clk);
    #1;
    chk(lp, 8'h00, "held while busy");
    @(posedge clk);
    bsy <= 4'h0;
    n = 0;
    while (lp[1:0] !== 2'h2 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(lp, 8'h02, "applied after frame");
    h.net_rd(OFF_STATUS, rd);
    chk(rd, 32'h00005825, "port 0 open");
  endtask
  task automatic s_close;
    // port 1 auto close, port 3 forced closed while its link is up
    h.net_wr(OFF_CONTROL, 4'b0010, 32'h0000C400);
    @(posedge clk);
    lnk <= 4'h8;
    @(posedge clk);
    lnk <= 4'hA;
    h.net_rd(OFF_STATUS, rd);
    chk(rd, 32'h00005DA5, "auto close held");
    @(posedge clk);
    fok <= 4'h2;
    @(posedge clk);
    fok <= 4'h0;
    h.net_rd(OFF_STATUS, rd);
    chk(rd, 32'h000059A5, "frame reopens");
  endtask
  task automatic s_rst2;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    load(3'h1, 1'b0);
    chk({fsz, trim}, 4'h3, "load after reset");
    h.net_rd(OFF_STATUS, rd);
    chk(rd, 32'h000019A1, "status after reset");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    s_reset();
    s_cfg();
    s_size();
    s_ctl();
    s_rld();
    s_alias();
    s_offset();
    s_loop();
    s_close();
    s_rst2();
    end_sim();
  end
  // a hang ends the run through the normal report
  initial begin
    #1ms;
    chk(0, 1, "timeout");
    end_sim();
  end
endmodule
`default_nettype wire
